// >>> verilog/intc_top.sv
`timescale 1ns/1ps
`default_nettype none
module intc_top
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sources
	input wire logic [15:0] src_req,
	input wire logic software_trap,
	// CPU core
	input wire logic instr_boundary,
	input wire logic irq_ack,
	input wire logic maskable_return_instruction,
	output logic cpu_irq_req,
	output logic [19:0] cpu_irq_vector,
	// Interrupt line
	output logic irq
);
	// ******************************
	// State
	// ******************************
	typedef struct packed {
		intc_pkg::fsm_t state;
		logic [15:0] request_latch;
		logic master_irq_enable;
		logic ext0_pin_enable;
		logic [15:0] source_irq_enable;
		logic [3:0] win_idx;
		logic [19:0] vec;
		logic [19:0] last_vec;
		logic [1:0] sts;
		logic [1:0] msk;
		logic [31:0] rdata;
	} state_t;

	state_t r_reg;
	state_t r_next;
	logic [15:0] elig;
	logic [15:0] set_vec;
	logic [15:0] win_onehot;
	logic [1:0] ev;
	logic wr;
	logic setup;
	logic accept;
	logic mapped;
	pick_if pk ();

	prio_pick u_pick
	(
		.p(pk)
	);

	// ******************************
	// Combinational helpers
	// ******************************
	assign wr = psel && penable && pwrite;
	assign setup = psel && !penable;
	assign accept = (r_reg.state == intc_pkg::ST_OFFER) && irq_ack;
	assign win_onehot = 16'h0001 << r_reg.win_idx;
	assign mapped = (paddr == intc_pkg::OFF_CTRL) || (paddr == intc_pkg::OFF_ENABLE) ||
		(paddr == intc_pkg::OFF_LATCH) || (paddr == intc_pkg::OFF_VECTOR) ||
		(paddr == intc_pkg::OFF_IRQ_STATUS) || (paddr == intc_pkg::OFF_IRQ_MASK);

	always_comb
	begin
		set_vec = src_req & intc_pkg::LATCH_MASK;
		if (!r_reg.ext0_pin_enable)
		begin
			set_vec[intc_pkg::SRC_EXT0] = 1'b0;
		end
	end

	always_comb
	begin
		elig = r_reg.request_latch & r_reg.source_irq_enable & intc_pkg::ENABLE_MASK &
			{16{r_reg.master_irq_enable}};
		elig[intc_pkg::SRC_SWTRAP] = software_trap;
		elig[intc_pkg::SRC_WDT] = r_reg.request_latch[intc_pkg::SRC_WDT];
		elig[intc_pkg::SRC_EXT0] = r_reg.request_latch[intc_pkg::SRC_EXT0] &&
			r_reg.master_irq_enable && r_reg.ext0_pin_enable;
		elig[0] = 1'b0;
	end

	assign pk.req = elig;

	// ******************************
	// Next state
	// ******************************
	always_comb
	begin
		r_next = r_reg;
		ev = 2'h0;
		// Register read data captured in setup
		if (setup)
		begin
			case (paddr)
				intc_pkg::OFF_CTRL: r_next.rdata = {30'h00000000, r_reg.ext0_pin_enable,
					r_reg.master_irq_enable};
				intc_pkg::OFF_ENABLE: r_next.rdata = {16'h0000, r_reg.source_irq_enable};
				intc_pkg::OFF_LATCH: r_next.rdata = {16'h0000, r_reg.request_latch};
				intc_pkg::OFF_VECTOR: r_next.rdata = {12'h000, r_reg.last_vec};
				intc_pkg::OFF_IRQ_STATUS: r_next.rdata = {30'h00000000, r_reg.sts};
				intc_pkg::OFF_IRQ_MASK: r_next.rdata = {30'h00000000, r_reg.msk};
				default: r_next.rdata = 32'h00000000;
			endcase
		end
		// software edits, caller keeps master enable low
		if (wr)
		begin
			case (paddr)
				intc_pkg::OFF_CTRL:
				begin
					r_next.master_irq_enable = pwdata[intc_pkg::CTRL_MIE_BIT];
					r_next.ext0_pin_enable = pwdata[intc_pkg::CTRL_PIN_BIT];
				end
				intc_pkg::OFF_ENABLE: r_next.source_irq_enable = pwdata[15:0] & intc_pkg::ENABLE_MASK;
				// Zero bits clear latches, ones leave them
				intc_pkg::OFF_LATCH: r_next.request_latch = r_reg.request_latch & pwdata[15:0];
				intc_pkg::OFF_IRQ_MASK: r_next.msk = pwdata[1:0];
				default:
				begin
				end
			endcase
		end
		if (maskable_return_instruction)
		begin
			r_next.master_irq_enable = 1'b1;
		end
		case (r_reg.state)
			intc_pkg::ST_IDLE:
			begin
				if (instr_boundary && pk.found)
				begin
					r_next.state = intc_pkg::ST_OFFER;
					r_next.win_idx = pk.idx;
					r_next.vec = intc_pkg::VEC_TOP - {14'h0000, pk.idx, 2'b00};
				end
			end
			intc_pkg::ST_OFFER:
			begin
				if (irq_ack)
				begin
					r_next.state = intc_pkg::ST_IDLE;
					r_next.request_latch = r_next.request_latch & ~win_onehot;
					r_next.master_irq_enable = 1'b0;
					r_next.last_vec = r_reg.vec;
					ev[intc_pkg::EV_ACCEPT] = 1'b1;
					ev[intc_pkg::EV_PSEUDO_NMI] = r_reg.win_idx < intc_pkg::FIRST_MASKABLE;
				end
			end
			default: r_next.state = intc_pkg::ST_IDLE;
		endcase
		// new request wins over any clear
		r_next.request_latch = (r_next.request_latch | set_vec) & intc_pkg::LATCH_MASK;
		// Sticky status, write one to clear, set wins
		if (wr && (paddr == intc_pkg::OFF_IRQ_STATUS))
		begin
			r_next.sts = r_reg.sts & ~pwdata[1:0];
		end
		r_next.sts = r_next.sts | ev;
	end

	// ******************************
	// Registers
	// ******************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg <= '0;
			r_reg.state <= intc_pkg::ST_IDLE;
			r_reg.vec <= intc_pkg::VEC_RESET;
			r_reg.last_vec <= intc_pkg::VEC_RESET;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// ******************************
	// Outputs
	// ******************************
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = r_reg.rdata;
	assign cpu_irq_req = (r_reg.state == intc_pkg::ST_OFFER);
	assign cpu_irq_vector = r_reg.vec;
	assign irq = |(r_reg.sts & r_reg.msk);

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_offer_start;
		$rose(cpu_irq_req);
	endsequence

	sequence s_accept;
		(r_reg.state == intc_pkg::ST_OFFER) && irq_ack;
	endsequence

	sequence s_boundary_idle;
		instr_boundary && (r_reg.state == intc_pkg::ST_IDLE);
	endsequence

	sequence s_apb_access;
		psel && penable;
	endsequence

	sequence s_pseudo_accept;
		s_accept ##0 (r_reg.win_idx < intc_pkg::FIRST_MASKABLE);
	endsequence

	sequence s_ext0_shut;
		!r_reg.ext0_pin_enable && !r_reg.request_latch[intc_pkg::SRC_EXT0];
	endsequence

	a_offer_at_boundary: assert property (s_offer_start |-> $past(instr_boundary))
		else $error("request raised off an instruction boundary");
	a_offer_holds: assert property (cpu_irq_req && !irq_ack |=> cpu_irq_req && $stable(cpu_irq_vector))
		else $error("offer dropped or vector moved before acceptance");
	a_vector_map: assert property (cpu_irq_req |-> cpu_irq_vector == intc_pkg::VEC_TOP - {14'h0000, r_reg.win_idx, 2'b00})
		else $error("vector does not match source");
	a_accept_masks: assert property (s_accept |=> !r_reg.master_irq_enable && !cpu_irq_req)
		else $error("master enable still set after acceptance");
	a_latch_cleared: assert property (s_accept |=> (r_reg.request_latch & $past(win_onehot & ~set_vec)) == 16'h0000)
		else $error("accepted latch not cleared");
	a_latch_sets: assert property (src_req[4] |=> r_reg.request_latch[4])
		else $error("request did not set its latch");
	a_maskable_gate: assert property (s_offer_start ##0 (r_reg.win_idx >= intc_pkg::FIRST_MASKABLE) |->
		$past(r_reg.master_irq_enable) && (($past(r_reg.source_irq_enable) & (16'h0001 << r_reg.win_idx)) != 16'h0000))
		else $error("maskable source offered while disabled");
	a_ext0_gate: assert property (s_offer_start ##0 (r_reg.win_idx == 4'(intc_pkg::SRC_EXT0)) |->
		$past(r_reg.master_irq_enable && r_reg.ext0_pin_enable))
		else $error("line zero offered while gated");
	a_pick_lowest: assert property (s_offer_start |-> ($past(elig) & ((16'h0001 << r_reg.win_idx) - 16'h0001)) == 16'h0000)
		else $error("lower priority source won");
	a_return_enables: assert property (maskable_return_instruction && !irq_ack && !wr |=> r_reg.master_irq_enable)
		else $error("return did not set master enable");
	a_irq_level: assert property (irq == |(r_reg.sts & r_reg.msk))
		else $error("interrupt line wrong");

	// ******************************
	// Further checks
	// ******************************
	// acceptance recorded
	a_status_sets: assert property (s_accept |=> r_reg.sts[intc_pkg::EV_ACCEPT])
		else $error("acceptance not recorded in status");

	a_pseudo_status: assert property (s_pseudo_accept |=> r_reg.sts[intc_pkg::EV_PSEUDO_NMI])
		else $error("pseudo acceptance not recorded");

	a_wdt_unmasked: assert property (s_boundary_idle ##0 (r_reg.request_latch[intc_pkg::SRC_WDT] &&
		!software_trap) |=> cpu_irq_req && (r_reg.win_idx == 4'(intc_pkg::SRC_WDT)))
		else $error("watchdog request not offered");

	a_trap_unmasked: assert property (s_boundary_idle ##0 software_trap |=>
		cpu_irq_req && (r_reg.win_idx == 4'(intc_pkg::SRC_SWTRAP)))
		else $error("software trap not offered");

	a_ext0_no_latch: assert property (s_ext0_shut |=> !r_reg.request_latch[intc_pkg::SRC_EXT0])
		else $error("line zero latched while pin disabled");

	a_low_latches: assert property (r_reg.request_latch[1:0] == 2'b00)
		else $error("unused latch set");

	a_latch_no_set: assert property (1'b1 |=>
		(r_reg.request_latch & ~$past(r_reg.request_latch | set_vec)) == 16'h0000)
		else $error("latch set without a source request");

	a_no_offer_idle: assert property (!instr_boundary && (r_reg.state == intc_pkg::ST_IDLE) |=> !cpu_irq_req)
		else $error("offer raised without a boundary");

	a_no_offer_empty: assert property (s_boundary_idle ##0 !pk.found |=> !cpu_irq_req)
		else $error("offer raised with nothing eligible");

	a_offer_taken: assert property (s_boundary_idle ##0 pk.found |=> cpu_irq_req)
		else $error("eligible request not offered");

	a_last_vector: assert property (s_accept |=> r_reg.last_vec == $past(cpu_irq_vector))
		else $error("accepted vector not recorded");

	// Zero wait state bus
	a_zero_wait: assert property (s_apb_access |-> pready)
		else $error("bus access stalled");

	// Mapped access never errors
	a_mapped_ok: assert property (s_apb_access ##0 mapped |-> !pslverr)
		else $error("error on a mapped register");

	a_latch_read: assert property (setup && (paddr == intc_pkg::OFF_LATCH) |=>
		prdata == {16'h0000, $past(r_reg.request_latch)})
		else $error("latch read data wrong");

	// Status held until cleared
	a_status_sticky: assert property (r_reg.sts[intc_pkg::EV_ACCEPT] &&
		!(wr && (paddr == intc_pkg::OFF_IRQ_STATUS) && pwdata[intc_pkg::EV_ACCEPT]) |=> r_reg.sts[intc_pkg::EV_ACCEPT])
		else $error("status bit lost without a clear");
endmodule
`default_nettype wire

// >>> verilog/intc_pkg.sv
`default_nettype none
package intc_pkg;
	// ******************************
	// Register map (byte addresses)
	// ******************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ENABLE = 8'h04;
	localparam logic [7:0] OFF_LATCH = 8'h08;
	localparam logic [7:0] OFF_VECTOR = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	// ******************************
	// Fields and sources
	// ******************************
	localparam int CTRL_MIE_BIT = 0;
	localparam int CTRL_PIN_BIT = 1;
	localparam int NUM_SRC = 16;
	localparam int SRC_SWTRAP = 1;
	localparam int SRC_WDT = 2;
	localparam int SRC_EXT0 = 3;
	localparam logic [3:0] FIRST_MASKABLE = 4'h4;
	localparam logic [15:0] LATCH_MASK = 16'hFFFC;
	localparam logic [15:0] ENABLE_MASK = 16'hFFF0;
	localparam int EV_ACCEPT = 0;
	localparam int EV_PSEUDO_NMI = 1;
	localparam int EV_W = 2;
	// ******************************
	// Vector table
	// ******************************
	localparam int VEC_W = 20;
	localparam logic [VEC_W-1:0] VEC_TOP = 20'hFFFFC;
	localparam logic [VEC_W-1:0] VEC_RESET = 20'hFFFFC;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_OFFER = 2'b10} fsm_t;
endpackage
`default_nettype wire

// >>> verilog/pick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pick_if;
	logic [15:0] req;
	logic found;
	logic [3:0] idx;
	modport enc (input req, output found, output idx);
	modport user (output req, input found, input idx);
endinterface
`default_nettype wire

// >>> verilog/prio_pick.sv
`timescale 1ns/1ps
`default_nettype none
module prio_pick
(
	// Request vector in, winner out
	pick_if.enc p
);
	// Lowest index is the highest priority
	always_comb
	begin
		p.found = 1'b0;
		p.idx = 4'h0;
		for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			if (p.req[i])
			begin
				p.found = 1'b1;
				p.idx = 4'(i);
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic go,
	input wire logic ret,
	input wire logic [3:0] dly,
	// Controller side
	input wire logic cpu_irq_req,
	input wire logic [19:0] cpu_irq_vector,
	output logic instr_boundary,
	output logic irq_ack,
	output logic maskable_return_instruction,
	// Record of accepted vectors
	output logic [19:0] acc_vec,
	output logic [7:0] acc_n
);
	logic [3:0] cnt;
	assign instr_boundary = go;
	assign maskable_return_instruction = ret;
	// ****************
	// Acceptance
	// ****************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_ack <= 1'b0;
			cnt <= 4'h0;
			acc_vec <= 20'h00000;
			acc_n <= 8'h00;
		end
		else if (cpu_irq_req && !irq_ack && cnt == dly)
		begin
			irq_ack <= 1'b1;
			acc_vec <= cpu_irq_vector;
			acc_n <= acc_n + 8'h01;
		end
		else
		begin
			irq_ack <= 1'b0;
			cnt <= (cpu_irq_req && !irq_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, software_trap = 1'b0, go = 1'b0, ret = 1'b0;
	logic [15:0] src_req = 16'h0000;
	logic [3:0] dly = 4'h0;
	logic instr_boundary, irq_ack, mri, cpu_irq_req, irq;
	logic [19:0] cpu_irq_vector, acc_vec;
	logic [7:0] acc_n;
	int failures = 0, samples_checked = 0;
	always #10 pclk = ~pclk;
	intc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_req(src_req), .software_trap(software_trap), .instr_boundary(instr_boundary),
		.irq_ack(irq_ack), .maskable_return_instruction(mri), .cpu_irq_req(cpu_irq_req),
		.cpu_irq_vector(cpu_irq_vector), .irq(irq));
	cpu_model cpu (.pclk(pclk), .presetn(presetn), .go(go), .ret(ret), .dly(dly),
		.cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector), .instr_boundary(instr_boundary),
		.irq_ack(irq_ack), .maskable_return_instruction(mri), .acc_vec(acc_vec), .acc_n(acc_n));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, r, exp);
	endtask
	task automatic pulse(input logic [15:0] m);
		src_req <= m;
		@(posedge pclk);
		src_req <= 16'h0000;
		@(posedge pclk);
	endtask
	task automatic take(input logic [19:0] exp);
		logic [7:0] n;
		n = acc_n;
		go <= 1'b1;
		for (int i = 0; i < 60 && acc_n === n; i++) @(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		chk("vector", 32'(acc_vec), 32'(exp));
	endtask
	task automatic no_offer();
		go <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("no offer", 32'(cpu_irq_req), 32'h0);
		go <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#1000000;
		failures++;
		give_verdict();
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("ctrl", intc_pkg::OFF_CTRL, 32'h0);
		rd("latch", intc_pkg::OFF_LATCH, 32'h0);
		rd("last vector", intc_pkg::OFF_VECTOR, 32'h000FFFFC);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped err", 32'(e), 32'h1);
		chk("unmapped data", r, 32'h0);
		$display("test reset done");
		for (int n = 4; n < 16; n++)
		begin
			dly <= 4'(n % 6);
			apb(1'b1, intc_pkg::OFF_ENABLE, 32'h1 << n);
			pulse(16'h1 << n);
			rd("latch set", intc_pkg::OFF_LATCH, 32'h1 << n);
			if (n == 4)
				no_offer();
			apb(1'b1, intc_pkg::OFF_CTRL, 32'h1);
			take(20'hFFFFC - 20'(4 * n));
			rd("master after", intc_pkg::OFF_CTRL, 32'h0);
			rd("latch after", intc_pkg::OFF_LATCH, 32'h0);
		end
		$display("test vectors done");
		apb(1'b1, intc_pkg::OFF_ENABLE, 32'h0);
		pulse(16'h0040);
		apb(1'b1, intc_pkg::OFF_CTRL, 32'h1);
		no_offer();
		apb(1'b1, intc_pkg::OFF_CTRL, 32'h0);
		apb(1'b1, intc_pkg::OFF_LATCH, 32'h0);
		rd("latch cleared", intc_pkg::OFF_LATCH, 32'h0);
		apb(1'b1, intc_pkg::OFF_ENABLE, 32'hFFF0);
		pulse(16'h8210);
		apb(1'b1, intc_pkg::OFF_CTRL, 32'h1);
		take(20'hFFFEC);
		ret <= 1'b1;
		@(posedge pclk);
		ret <= 1'b0;
		take(20'hFFFD8);
		ret <= 1'b1;
		@(posedge pclk);
		ret <= 1'b0;
		take(20'hFFFC0);
		$display("test priority done");
		pulse(16'h0004);
		take(20'hFFFF4);
		software_trap <= 1'b1;
		take(20'hFFFF8);
		software_trap <= 1'b0;
		apb(1'b1, intc_pkg::OFF_CTRL, 32'h1);
		pulse(16'h0008);
		no_offer();
		apb(1'b1, intc_pkg::OFF_CTRL, 32'h3);
		pulse(16'h0008);
		take(20'hFFFF0);
		$display("test pseudo and line zero done");
		rd("status", intc_pkg::OFF_IRQ_STATUS, 32'h3);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b1, intc_pkg::OFF_IRQ_MASK, 32'h1);
		chk("irq raised", 32'(irq), 32'h1);
		apb(1'b1, intc_pkg::OFF_IRQ_STATUS, 32'h3);
		rd("status cleared", intc_pkg::OFF_IRQ_STATUS, 32'h0);
		chk("irq cleared", 32'(irq), 32'h0);
		$display("test interrupt done");
		give_verdict();
	end
endmodule
`default_nettype wire
